// ===== hw/ohb_busy_timer.sv
// Purpose: Busy timer; busy rises on start and falls after a cycle count.
// Assumes: Count is at least one cycle.
// Notes: A start while busy is ignored.
`timescale 1ns/1ps
module ohb_busy_timer #(
  parameter int CYCLES = 64
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic start,
  output logic busy,
  output logic done
);
  logic [31:0] count;

  // Load on start, count down, pulse done at the end.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count <= 32'h0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else if (ce)
    begin
      done <= 1'b0;
      if (!busy && start)
      begin
        count <= 32'(CYCLES - 1);
        busy <= 1'b1;
      end
      else if (busy && count == 32'h0)
      begin
        busy <= 1'b0;
        done <= 1'b1;
      end
      else if (busy)
        count <= count - 32'h1;
    end
  end
endmodule // ohb_busy_timer

// ===== hw/ohb_ctrl.sv
// Purpose: Hot-reset output hold, safety output and busy flags of a
//   64-channel output card, reached over AXI4-Lite.
// Assumes: power_on_resetn is the full power-on reset; aresetn is the
//   hot system reset; wdt_int is the watchdog interrupt level.
// Notes: Power-on reset clears all; hot reset spares the hold bit.
// Summary of operation
// - Hold enabled: hot reset keeps outputs.
// - Hold disabled: hot reset drives defaults.
// - Hold enable bit writable, resets to 0.
// - Hold enable bit reads back its state.
// - Safety enable bit reads back its state.
// - Flash busy flag shows write progress.
// - Send busy flag shows output sending.
// - Read-back busy flag shows read-back.
// - Watchdog drives safety values if enabled.
// - Last default write starts 0.5 s flash.
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module ohb_ctrl
  import ohb_pkg::*;
#(
  parameter int FLASH_CYCLES = FLASH_WRITE_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic power_on_resetn,
  input wire logic ce,
  input wire logic wdt_int,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [63:0] dout
);
  logic hold_en;
  logic safe_en;
  logic [63:0] out_reg;
  logic [63:0] def_val;
  logic [63:0] safe_val;
  logic [63:0] staged;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic hot_pending;
  logic wdt_prev;
  logic flash_busy;
  logic send_busy;
  logic rb_busy;
  logic send_done;
  ohb_state_t state;

  // Power-on reset also clears everything that the hot reset clears.
  wire sys_rstn = aresetn && power_on_resetn;

  // Write decode, taken when both address and data are held.
  wire wr_fire = aw_held && w_held && !s_axi_bvalid;
  wire wr_lane0 = w_strb[0];
  wire wr_ctrl = wr_fire && aw_addr == OFF_CTRL && wr_lane0;
  wire wr_do_lo = wr_fire && aw_addr == OFF_DO_LO;
  wire wr_do_hi = wr_fire && aw_addr == OFF_DO_HI;
  wire wr_def_a = wr_fire && aw_addr == OFF_DEF_A;
  wire wr_def_b = wr_fire && aw_addr == OFF_DEF_B;
  wire wr_def_c = wr_fire && aw_addr == OFF_DEF_C;
  wire wr_def_d = wr_fire && aw_addr == OFF_DEF_D;
  wire wr_cmd = wr_fire && aw_addr == OFF_CMD && wr_lane0;
  wire wr_safe_lo = wr_fire && aw_addr == OFF_SAFE_LO;
  wire wr_safe_hi = wr_fire && aw_addr == OFF_SAFE_HI;
  wire wr_known = wr_ctrl || wr_do_lo || wr_do_hi || wr_def_a ||
    wr_def_b || wr_def_c || wr_def_d || wr_cmd || wr_safe_lo || wr_safe_hi;
  wire [15:0] wr_half = {w_strb[1] ? w_data[15:8] : 8'h00,
    w_strb[0] ? w_data[7:0] : 8'h00};
  wire start_send = wr_cmd && w_data[BIT_CMD_SEND];
  wire start_rb = wr_cmd && w_data[BIT_CMD_RB];
  wire wdt_rise = wdt_int && !wdt_prev;
  wire [2:0] busy_bits = {rb_busy, send_busy, flash_busy};

  // Read decode.
  wire rd_fire = s_axi_arvalid && !s_axi_rvalid;
  wire [31:0] rd_ctrl = {30'h0, safe_en, hold_en};
  wire [31:0] rd_status = {29'h0, busy_bits};
  wire rd_known = s_axi_araddr == OFF_CTRL || s_axi_araddr == OFF_STATUS ||
    s_axi_araddr == OFF_DO_LO || s_axi_araddr == OFF_DO_HI;
  wire [31:0] rd_mux =
    s_axi_araddr == OFF_CTRL ? rd_ctrl :
    s_axi_araddr == OFF_STATUS ? rd_status :
    s_axi_araddr == OFF_DO_LO ? out_reg[31:0] :
    s_axi_araddr == OFF_DO_HI ? out_reg[63:32] : 32'h0;

  // Hold enable survives hot reset; only power-on clears it.
  always_ff @(posedge aclk)
  begin
    if (!power_on_resetn)
      hold_en <= 1'b0;
    else if (ce && wr_ctrl)
      hold_en <= w_data[BIT_HOLD_EN];
  end

  // Output latch and stored values also live across hot reset.
  always_ff @(posedge aclk)
  begin
    if (!power_on_resetn)
    begin
      out_reg <= DO_RESET;
      def_val <= DO_RESET;
      safe_val <= DO_RESET;
      staged <= DO_RESET;
      hot_pending <= 1'b0;
    end
    else if (!aresetn)
      hot_pending <= 1'b1;
    else if (ce)
    begin
      hot_pending <= 1'b0;
      if (hot_pending && !hold_en)
        out_reg <= def_val;
      else if (hot_pending)
        out_reg <= out_reg;
      else if (wdt_rise && safe_en)
        out_reg <= safe_val;
      else if (send_done && !wdt_int)
        out_reg <= staged;
      if (wr_do_lo)
        staged[31:0] <= w_data;
      if (wr_do_hi)
        staged[63:32] <= w_data;
      if (wr_def_a)
        def_val[15:0] <= wr_half;
      if (wr_def_b)
        def_val[31:16] <= wr_half;
      if (wr_def_c)
        def_val[47:32] <= wr_half;
      if (wr_def_d)
        def_val[63:48] <= wr_half;
      if (wr_safe_lo)
        safe_val[31:0] <= w_data;
      if (wr_safe_hi)
        safe_val[63:32] <= w_data;
    end
  end

  // Safety enable and watchdog edge follow either reset.
  always_ff @(posedge aclk)
  begin
    if (!sys_rstn)
    begin
      safe_en <= 1'b0;
      wdt_prev <= 1'b0;
    end
    else if (ce)
    begin
      wdt_prev <= wdt_int;
      if (wr_ctrl)
        safe_en <= w_data[BIT_SAFE_EN];
    end
  end

  // Busy timers for flash, send and read-back jobs.
  ohb_busy_timer #(.CYCLES(FLASH_CYCLES)) u_flash (
    .aclk(aclk), .aresetn(sys_rstn), .ce(ce),
    .start(wr_def_d),
    .busy(flash_busy), .done()
  );
  ohb_busy_timer #(.CYCLES(SEND_CYC)) u_send (
    .aclk(aclk), .aresetn(sys_rstn), .ce(ce),
    .start(start_send),
    .busy(send_busy), .done(send_done)
  );
  ohb_busy_timer #(.CYCLES(RB_CYC)) u_rb (
    .aclk(aclk), .aresetn(sys_rstn), .ce(ce),
    .start(start_rb),
    .busy(rb_busy), .done()
  );

  // Summary state of the job engine, flash has priority in the report.
  always_ff @(posedge aclk)
  begin
    if (!sys_rstn)
      state <= OHB_IDLE;
    else if (ce)
    begin
      case (1'b1)
        flash_busy: state <= OHB_FLASH;
        send_busy: state <= OHB_SEND;
        rb_busy: state <= OHB_RB;
        default: state <= OHB_IDLE;
      endcase
    end
  end

  // AXI write channels: capture address and data in either order.
  always_ff @(posedge aclk)
  begin
    if (!sys_rstn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (ce)
    begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // AXI read channels: one cycle from address to data.
  always_ff @(posedge aclk)
  begin
    if (!sys_rstn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (ce)
    begin
      s_axi_arready <= rd_fire && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Outputs come from the output latch.
  always_ff @(posedge aclk)
  begin
    if (!power_on_resetn)
      dout <= DO_RESET;
    else if (ce)
      dout <= out_reg;
  end
endmodule // ohb_ctrl

// ===== include/ohb_pkg.sv
// Purpose: Constants for the output hold and busy flag block.
// Assumes: 32-bit AXI4-Lite register bus, 50 MHz clock.
// Notes: Offsets are byte addresses of aligned words.
package ohb_pkg;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_DO_LO = 8'h08;
  localparam logic [7:0] OFF_DO_HI = 8'h0c;
  localparam logic [7:0] OFF_DEF_A = 8'h10;
  localparam logic [7:0] OFF_DEF_B = 8'h14;
  localparam logic [7:0] OFF_DEF_C = 8'h18;
  localparam logic [7:0] OFF_DEF_D = 8'h1c;
  localparam logic [7:0] OFF_CMD = 8'h20;
  localparam logic [7:0] OFF_SAFE_LO = 8'h24;
  localparam logic [7:0] OFF_SAFE_HI = 8'h28;
  // CTRL fields.
  localparam int BIT_HOLD_EN = 0;
  localparam int BIT_SAFE_EN = 1;
  // STATUS fields.
  localparam int BIT_FLASH_BUSY = 0;
  localparam int BIT_SEND_BUSY = 1;
  localparam int BIT_RB_BUSY = 2;
  // CMD fields.
  localparam int BIT_CMD_SEND = 0;
  localparam int BIT_CMD_RB = 1;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [63:0] DO_RESET = 64'h0;
  localparam int CLK_HZ = 50000000;
  localparam int FLASH_WRITE_MS = 500;
  localparam int FLASH_WRITE_CYC = (CLK_HZ / 1000) * FLASH_WRITE_MS;
  localparam int SEND_CYC = 64;
  localparam int RB_CYC = 64;
  typedef enum logic [3:0] {
    OHB_IDLE = 4'b0001,
    OHB_SEND = 4'b0010,
    OHB_RB = 4'b0100,
    OHB_FLASH = 4'b1000
  } ohb_state_t;
endpackage

// ===== tb/ohb_ctrl_monitor.sv
// Purpose: Port-level assertions for the output hold block.
// Assumes: Both resets are synchronous and active low.
// Notes: Bound to every instance of the block.
`timescale 1ns/1ps
module ohb_ctrl_monitor
  import ohb_pkg::*;
#(
  parameter int FLASH_CYCLES = 100
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic power_on_resetn,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [63:0] dout
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn || !power_on_resetn);
  // Address handshakes that start a transfer.
  sequence s_ar;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_aw;
    s_axi_awvalid && s_axi_awready;
  endsequence
  // Reset, bus timing and hold behaviour seen at the ports.
  AST_PO_CLEAR: assert property (disable iff (1'b0)
    !power_on_resetn && ce |=> dout == DO_RESET) else $error("dout not 0");
  AST_HOT_KEEP: assert property (disable iff (!power_on_resetn)
    !aresetn && ce |=> $stable(dout)) else $error("dout moved in reset");
  AST_RD_LAT: assert property (s_ar |=> s_axi_rvalid)
    else $error("rvalid late");
  AST_AR_READY: assert property (s_axi_arvalid && !s_axi_arready
    |=> s_axi_arready) else $error("arready late");
  AST_AW_READY: assert property (s_axi_awvalid && !s_axi_awready
    |=> s_axi_awready) else $error("awready late");
  AST_WR_RESP: assert property (s_aw |-> ##[1:3] s_axi_bvalid)
    else $error("bvalid late");
  AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid) else $error("bvalid stuck");
  AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid) else $error("rvalid stuck");
endmodule // ohb_ctrl_monitor

bind ohb_ctrl ohb_ctrl_monitor #(.FLASH_CYCLES(FLASH_CYCLES)) i_mon (.*);

// ===== tb/ohb_ctrl_tb.sv
// Purpose: Self-checking bench for the output hold block.
// Assumes: Flash busy time is shortened to 100 cycles.
// Notes: A small model predicts outputs and register reads.
`timescale 1ns/1ps
module ohb_ctrl_tb;
  import ohb_pkg::*;
  logic aclk = 0, aresetn = 0, power_on_resetn = 0, ce = 1, wdt_int = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_r;
  logic [31:0] s_axi_rdata, rd_d;
  logic [63:0] dout, m_def, m_do, m_safe;
  int seed = 8;
  int miscompares = 0;
  int n_checks = 0;
  int i;
  ohb_ctrl #(.FLASH_CYCLES(100)) i_dut (.*);
  // Clock of 20 ns period.
  always #10 aclk = ~aclk;
  // Prints the counts and the verdict, then stops.
  task end_sim;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // A wait that ran out counts as a mismatch.
  task tmo;
    miscompares++;
    $display("MISMATCH %0t wait ran out", $time);
    end_sim();
  endtask
  // Compares one result with the model.
  task chk(input logic [63:0] g, input logic [63:0] e);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  // One AXI4-Lite write; each channel held until its ready.
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    wr_r = s_axi_bresp;
    if (!s_axi_bvalid) tmo();
    @(posedge aclk);
  endtask
  // One AXI4-Lite read; data and response land in rd_d and rd_r.
  task rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    if (!s_axi_rvalid) tmo();
    @(posedge aclk);
  endtask
  // A status flag must read busy, then clear within the poll bound.
  task busy(input int b);
    int n;
    n = 0;
    rd(OFF_STATUS);
    chk(rd_d[b], 1'b1);
    while (rd_d[b] !== 1'b0 && n < 100)
    begin
      rd(OFF_STATUS);
      n++;
    end
    if (rd_d[b] !== 1'b0) tmo();
  endtask
  // Hot reset pulse, then time for the outputs to settle.
  task hot;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask
  // Main sequence.
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    power_on_resetn <= 1'b1;
    @(posedge aclk);
    rd(OFF_CTRL);
    chk(rd_d, 0);
    rd(OFF_STATUS);
    chk(rd_d, 0);
    for (i = 0; i < 4; i++)
    begin
      wr(OFF_CTRL, i);
      chk(wr_r, RESP_OKAY);
      rd(OFF_CTRL);
      chk(rd_d[1:0], i[1:0]);
    end
    m_def = {$random(seed), $random(seed)};
    for (i = 0; i < 4; i++)
      wr(OFF_DEF_A + 8'(4 * i), 32'(m_def[16 * i +: 16]));
    busy(BIT_FLASH_BUSY);
    m_do = {$random(seed), $random(seed)};
    wr(OFF_DO_LO, m_do[31:0]);
    wr(OFF_DO_HI, m_do[63:32]);
    wr(OFF_CMD, 32'h1);
    busy(BIT_SEND_BUSY);
    chk(dout, m_do);
    wr(OFF_CMD, 32'h2);
    busy(BIT_RB_BUSY);
    rd(8'h3c);
    chk(rd_r, RESP_SLVERR);
    wr(8'h3c, 32'h0);
    chk(wr_r, RESP_SLVERR);
    wr(OFF_CTRL, 32'h3);
    hot();
    chk(dout, m_do);
    rd(OFF_CTRL);
    chk(rd_d, 32'h1);
    wr(OFF_CTRL, 32'h0);
    hot();
    chk(dout, m_def);
    m_safe = {$random(seed), $random(seed)};
    wr(OFF_SAFE_LO, m_safe[31:0]);
    wr(OFF_SAFE_HI, m_safe[63:32]);
    for (i = 0; i < 2; i++)
    begin
      wr(OFF_CTRL, 32'(2 * i));
      wdt_int <= 1'b1;
      repeat (3) @(posedge aclk);
      wdt_int <= 1'b0;
      chk(dout, i ? m_safe : m_def);
    end
    // Clock enable low: a watchdog edge must not reach the outputs.
    hot();
    chk(dout, m_def);
    wr(OFF_CTRL, 32'h2);
    ce <= 1'b0;
    wdt_int <= 1'b1;
    repeat (3) @(posedge aclk);
    wdt_int <= 1'b0;
    @(posedge aclk);
    ce <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(dout, m_def);
    power_on_resetn <= 1'b0;
    repeat (2) @(posedge aclk);
    power_on_resetn <= 1'b1;
    @(posedge aclk);
    chk(dout, DO_RESET);
    rd(OFF_CTRL);
    chk(rd_d, 0);
    end_sim();
  end
  // Overall guard against a hang.
  initial
  begin
    #400000;
    tmo();
  end
endmodule // ohb_ctrl_tb
